// *** pkg/pin_mux_regs.svh ***
`ifndef PIN_MUX_REGS_SVH
`define PIN_MUX_REGS_SVH

// ****************************************************************
// field widths and reset values
// ****************************************************************
`define PP_MODE_W        3
`define SP_MODE_W        2
`define PP_MODE_RST      3'h0
`define SP_MODE_RST      2'h0
`define PP_MODE_RSVD     3'h7
`define SP_MODE_RSVD     2'h3
`define LCD_PD_W         14
`define SD_PD_W          12
`define LCD_PD_RST       14'h0000
`define SD_PD_RST        12'h000

// ****************************************************************
// pin indices and counts
// ****************************************************************
`define PIN_CNT          33
`define GRP_CNT          10
`define SIG_CNT          32
`define PIN_LCD_D2       2
`define PIN_LCD_D8       8
`define PIN_LCD_D12      12
`define PIN_LCD_EN       16
`define PIN_LCD_CS0      17
`define PIN_SD0_CLK      21
`define PIN_SD1_CLK      27
`define PIN_SD_LAST      32

// ****************************************************************
// signal indices inside a group
// ****************************************************************
`define SPI_CLK          5'h00
`define SPI_RX           5'h01
`define SPI_TX           5'h02
`define SPI_CS0          5'h03
`define GPIO_LCD_LO      5'h0C
`define GPIO_SD1_BASE    5'h06
`define GPIO_SD0_BASE    5'h00

`endif

// *** pkg/pin_mux_pkg.sv ***
package pin_mux_pkg;

   // ****************************************************************
   // function groups, signal selects and mode codes
   // ****************************************************************
   typedef enum logic [3:0] {
      GRP_LCD  = 4'h0,
      GRP_SPI  = 4'h1,
      GRP_UART = 4'h2,
      GRP_I2S0 = 4'h3,
      GRP_I2S1 = 4'h4,
      GRP_I2S2 = 4'h5,
      GRP_I2S3 = 4'h6,
      GRP_SD0  = 4'h7,
      GRP_SD1  = 4'h8,
      GRP_GPIO = 4'h9
   } func_grp_type;

   typedef struct packed {
      func_grp_type grp;
      logic [4:0]   idx;
   } pin_sel_type;

   typedef enum logic [2:0] {
      PP_LCD       = 3'h0,
      PP_SPI_I2S2  = 3'h1,
      PP_GPIO      = 3'h2,
      PP_SPI_I2S3  = 3'h3,
      PP_I2S2_UART = 3'h4,
      PP_SPI_UART  = 3'h5,
      PP_I2S2_I2S3 = 3'h6,
      PP_RSVD      = 3'h7
   } pp_mode_type;

   typedef enum logic [1:0] {
      SP_SD   = 2'h0,
      SP_I2S  = 2'h1,
      SP_GPIO = 2'h2,
      SP_RSVD = 2'h3
   } sp_mode_type;

endpackage

// *** pkg/mux_sel_if.sv ***
`timescale 1ns/1ps
`include "pin_mux_regs.svh"

interface mux_sel_if;
   import pin_mux_pkg::*;

   logic [`PP_MODE_W-1:0] pp_mode;
   logic [`SP_MODE_W-1:0] sp0_mode;
   logic [`SP_MODE_W-1:0] sp1_mode;
   pin_sel_type           sel [`PIN_CNT];

   modport owner   (output pp_mode, output sp0_mode, output sp1_mode, input sel);
   modport decoder (input pp_mode, input sp0_mode, input sp1_mode, output sel);
endinterface

// *** src/pin_select_decode.sv ***
`timescale 1ns/1ps
`include "pin_mux_regs.svh"

module pin_select_decode (
   mux_sel_if.decoder sel_if
);
   import pin_mux_pkg::*;

   // ****************************************************************
   // helpers
   // ****************************************************************
   // reserved codes fall back to the reset mapping
   function automatic pp_mode_type norm_pp(input logic [`PP_MODE_W-1:0] m);
      norm_pp = (m == `PP_MODE_RSVD) ? PP_LCD : pp_mode_type'(m);
   endfunction

   function automatic sp_mode_type norm_sp(input logic [`SP_MODE_W-1:0] m);
      norm_sp = (m == `SP_MODE_RSVD) ? SP_SD : sp_mode_type'(m);
   endfunction

   // lcd pins carry clk, fs, rx, dx; group order is clk, fs, dx, rx
   function automatic logic [4:0] lcd_i2s_idx(input logic [1:0] k);
      lcd_i2s_idx = (k == 2'h2) ? 5'h03 : (k == 2'h3) ? 5'h02 : {3'h0, k};
   endfunction

   function automatic pin_sel_type sd_sel(input sp_mode_type m, input func_grp_type sd_grp,
                                          input func_grp_type i2s_grp, input logic [4:0] k,
                                          input logic [4:0] gpio_base);
      logic [4:0] gpio_num;
      gpio_num = 5'(gpio_base + k);
      case (m)
         SP_I2S:  sd_sel = (k < 5'h04) ? '{i2s_grp, k} : '{GRP_GPIO, gpio_num};
         SP_GPIO: sd_sel = '{GRP_GPIO, gpio_num};
         default: sd_sel = '{sd_grp, k};
      endcase
   endfunction

   // ****************************************************************
   // per pin function selection
   // ****************************************************************
   pp_mode_type pp;
   sp_mode_type sp0;
   sp_mode_type sp1;
   logic        pp_spi;

   assign pp     = norm_pp(sel_if.pp_mode);    // RQ8
   assign sp0    = norm_sp(sel_if.sp0_mode);   // RQ8
   assign sp1    = norm_sp(sel_if.sp1_mode);   // RQ8
   assign pp_spi = (pp == PP_SPI_I2S2) || (pp == PP_I2S2_I2S3);

   always_comb begin
      for (int p = 0; p < `PIN_CNT; p++) begin
         logic [4:0] k;
         k = 5'(p);
         sel_if.sel[p] = '{GRP_LCD, k};   // RQ1
         if (p < `PIN_LCD_D2) begin
            if (pp_spi) sel_if.sel[p] = '{GRP_SPI, 5'(`SPI_RX + p)};   // RQ2
         end else if (p < `PIN_LCD_D8) begin
            if (pp_spi) sel_if.sel[p] = '{GRP_GPIO, 5'(`GPIO_LCD_LO + p - `PIN_LCD_D2)};   // RQ2
         end else if (p < `PIN_LCD_D12) begin
            k = 5'(p - `PIN_LCD_D8);
            case (pp)   // RQ3
               PP_SPI_I2S2, PP_I2S2_UART, PP_I2S2_I2S3:
                  sel_if.sel[p] = '{GRP_I2S2, lcd_i2s_idx(k[1:0])};
               PP_GPIO:
                  sel_if.sel[p] = '{GRP_GPIO, (k == 5'h03) ? 5'h1B : 5'(5'h12 + k)};
               PP_SPI_I2S3, PP_SPI_UART:
                  sel_if.sel[p] = '{GRP_SPI, (k == 5'h00) ? `SPI_CLK : (k == 5'h01) ? `SPI_CS0
                                            : (k == 5'h02) ? `SPI_RX : `SPI_TX};
               default: ;
            endcase
         end else if (p < `PIN_LCD_EN) begin
            k = 5'(p - `PIN_LCD_D12);
            case (pp)   // RQ3
               PP_SPI_I2S2, PP_I2S2_UART, PP_SPI_UART:
                  sel_if.sel[p] = '{GRP_UART, k};
               PP_GPIO:
                  sel_if.sel[p] = '{GRP_GPIO, 5'(5'h1C + k)};
               PP_SPI_I2S3, PP_I2S2_I2S3:
                  sel_if.sel[p] = '{GRP_I2S3, lcd_i2s_idx(k[1:0])};
               default: ;
            endcase
         end else if (p == `PIN_LCD_EN) begin
            if (pp_spi) sel_if.sel[p] = '{GRP_SPI, `SPI_CLK};   // RQ2
         end else if (p < `PIN_SD0_CLK) begin
            if (pp_spi) sel_if.sel[p] = '{GRP_SPI, 5'(`SPI_CS0 + p - `PIN_LCD_CS0)};   // RQ2
         end else if (p < `PIN_SD1_CLK) begin
            sel_if.sel[p] = sd_sel(sp0, GRP_SD0, GRP_I2S0, 5'(p - `PIN_SD0_CLK),
                                   `GPIO_SD0_BASE);   // RQ5
         end else begin
            sel_if.sel[p] = sd_sel(sp1, GRP_SD1, GRP_I2S1, 5'(p - `PIN_SD1_CLK),
                                   `GPIO_SD1_BASE);   // RQ4
         end
      end
   end

endmodule

// *** src/peripheral_pin_mux.sv ***
// Contract
// RQ1 - 3-bit parallel mode, reset 000 gives LCD
// RQ2 - codes 001/110: SPI control, GPIO 12-17
// RQ3 - LCD data 8-15 mapped per parallel code
// RQ4 - serial port 1 mode maps SD1 pins
// RQ5 - serial port 0 mode maps SD0 pins
// RQ6 - pulldown inhibit per LCD data 2-15
// RQ7 - pulldown inhibit per SD pin
// RQ8 - reserved codes keep reset default mapping
// RQ9 - software resets peripherals after mux change
`timescale 1ns/1ps
`include "pin_mux_regs.svh"

module peripheral_pin_mux (
   // clock and reset
   input  wire logic                                     CLK_I,
   input  wire logic                                     ARST_N_I,
   // bus selection register write
   input  wire logic                                     SEL_WR_I,
   input  wire logic [`PP_MODE_W-1:0]                    PP_MODE_I,
   input  wire logic [`SP_MODE_W-1:0]                    SP1_MODE_I,
   input  wire logic [`SP_MODE_W-1:0]                    SP0_MODE_I,
   // pulldown inhibit writes
   input  wire logic                                     LCD_PD_WR_I,
   input  wire logic [`LCD_PD_W-1:0]                     LCD_PD_INHIBIT_I,
   input  wire logic                                     SD_PD_WR_I,
   input  wire logic [`SD_PD_W-1:0]                      SD_PD_INHIBIT_I,
   // peripheral side
   input  wire logic [`GRP_CNT-1:0][`SIG_CNT-1:0]        FUNC_OUT_I,
   input  wire logic [`GRP_CNT-1:0][`SIG_CNT-1:0]        FUNC_OE_I,
   output logic      [`GRP_CNT-1:0][`SIG_CNT-1:0]        FUNC_IN_O,
   // pad side
   input  wire logic [`PIN_CNT-1:0]                      PAD_IN_I,
   output logic      [`PIN_CNT-1:0]                      PAD_OUT_O,
   output logic      [`PIN_CNT-1:0]                      PAD_OE_O,
   output logic      [`PIN_CNT-1:0]                      PAD_PD_EN_O,
   // status
   output logic      [`PP_MODE_W-1:0]                    PP_MODE_O,
   output logic      [`SP_MODE_W-1:0]                    SP1_MODE_O,
   output logic      [`SP_MODE_W-1:0]                    SP0_MODE_O,
   output pin_mux_pkg::pin_sel_type [`PIN_CNT-1:0]       PIN_SEL_O
);
   import pin_mux_pkg::*;

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   logic [`PP_MODE_W-1:0] pp_mode_q;
   logic [`SP_MODE_W-1:0] sp1_mode_q;
   logic [`SP_MODE_W-1:0] sp0_mode_q;
   logic [`LCD_PD_W-1:0]  lcd_pd_inh_q;
   logic [`SD_PD_W-1:0]   sd_pd_inh_q;

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         pp_mode_q  <= `PP_MODE_RST;   // RQ1
         sp1_mode_q <= `SP_MODE_RST;   // RQ4
         sp0_mode_q <= `SP_MODE_RST;   // RQ5
      end else if (SEL_WR_I) begin
         pp_mode_q  <= PP_MODE_I;
         sp1_mode_q <= SP1_MODE_I;
         sp0_mode_q <= SP0_MODE_I;
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         lcd_pd_inh_q <= `LCD_PD_RST;
         sd_pd_inh_q  <= `SD_PD_RST;
      end else begin
         if (LCD_PD_WR_I) lcd_pd_inh_q <= LCD_PD_INHIBIT_I;   // RQ6
         if (SD_PD_WR_I) sd_pd_inh_q <= SD_PD_INHIBIT_I;      // RQ7
      end
   end

   // ****************************************************************
   // function decode
   // ****************************************************************
   mux_sel_if sel_if ();

   assign sel_if.pp_mode  = pp_mode_q;
   assign sel_if.sp0_mode = sp0_mode_q;
   assign sel_if.sp1_mode = sp1_mode_q;

   pin_select_decode u_decode (
      .sel_if (sel_if.decoder)
   );

   // ****************************************************************
   // pad output selection
   // ****************************************************************
   logic [`PIN_CNT-1:0] pad_out_d;
   logic [`PIN_CNT-1:0] pad_oe_d;
   logic [`PIN_CNT-1:0] pd_en_d;
   pin_sel_type [`PIN_CNT-1:0] sel_d;

   for (genvar p = 0; p < `PIN_CNT; p++) begin : g_pin
      wire pin_sel_type s = sel_if.sel[p];
      assign sel_d[p]     = s;
      assign pad_out_d[p] = FUNC_OUT_I[s.grp][s.idx];   // RQ2 RQ3 RQ4 RQ5
      assign pad_oe_d[p]  = FUNC_OE_I[s.grp][s.idx];
      if (p >= `PIN_LCD_D2 && p < `PIN_LCD_EN) begin : g_lcd_pd
         assign pd_en_d[p] = ~lcd_pd_inh_q[p - `PIN_LCD_D2];   // RQ6
      end else if (p >= `PIN_SD0_CLK) begin : g_sd_pd
         assign pd_en_d[p] = ~sd_pd_inh_q[p - `PIN_SD0_CLK];   // RQ7
      end else begin : g_no_pd
         assign pd_en_d[p] = 1'b0;
      end
   end

   // ****************************************************************
   // peripheral input routing
   // ****************************************************************
   logic [`GRP_CNT-1:0][`SIG_CNT-1:0] func_in_d;

   always_comb begin
      func_in_d = '0;
      for (int p = 0; p < `PIN_CNT; p++) begin
         func_in_d[sel_d[p].grp][sel_d[p].idx] = PAD_IN_I[p];
      end
   end

   // ****************************************************************
   // output registers
   // ****************************************************************
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         PAD_OUT_O   <= '0;
         PAD_OE_O    <= '0;
         PAD_PD_EN_O <= '0;
         FUNC_IN_O   <= '0;
         PIN_SEL_O   <= '0;
      end else begin
         PAD_OUT_O   <= pad_out_d;
         PAD_OE_O    <= pad_oe_d;
         PAD_PD_EN_O <= pd_en_d;
         FUNC_IN_O   <= func_in_d;
         PIN_SEL_O   <= sel_d;
      end
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         PP_MODE_O  <= `PP_MODE_RST;
         SP1_MODE_O <= `SP_MODE_RST;
         SP0_MODE_O <= `SP_MODE_RST;
      end else begin
         PP_MODE_O  <= pp_mode_q;
         SP1_MODE_O <= sp1_mode_q;
         SP0_MODE_O <= sp0_mode_q;
      end
   end

endmodule

// *** dv/peripheral_pin_mux_asserts.sv ***
`timescale 1ns/1ps
`include "pin_mux_regs.svh"

module peripheral_pin_mux_asserts (
   // clock and reset
   input wire logic                             CLK_I,
   input wire logic                             ARST_N_I,
   // configuration writes
   input wire logic                             SEL_WR_I,
   input wire logic [`PP_MODE_W-1:0]            PP_MODE_I,
   input wire logic [`SP_MODE_W-1:0]            SP1_MODE_I,
   input wire logic [`SP_MODE_W-1:0]            SP0_MODE_I,
   input wire logic                             LCD_PD_WR_I,
   input wire logic [`LCD_PD_W-1:0]             LCD_PD_INHIBIT_I,
   input wire logic                             SD_PD_WR_I,
   input wire logic [`SD_PD_W-1:0]              SD_PD_INHIBIT_I,
   // observed outputs
   input wire logic [`PIN_CNT-1:0]              PAD_PD_EN_O,
   input wire logic [`PP_MODE_W-1:0]            PP_MODE_O,
   input wire logic [`SP_MODE_W-1:0]            SP1_MODE_O,
   input wire logic [`SP_MODE_W-1:0]            SP0_MODE_O,
   input wire pin_mux_pkg::pin_sel_type [`PIN_CNT-1:0] PIN_SEL_O
);
   import pin_mux_pkg::*;

   // ********************************
   // checks
   // ********************************
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);

   a_pp_echo: assert property (SEL_WR_I |-> ##2 PP_MODE_O == $past(PP_MODE_I, 2))
      else $error("parallel mode readback wrong");
   a_mode_hold: assert property (!SEL_WR_I |-> ##2 $stable(PP_MODE_O))
      else $error("parallel mode changed without write");
   a_sp_echo: assert property (SEL_WR_I |-> ##2 {SP1_MODE_O, SP0_MODE_O} ==
      {$past(SP1_MODE_I, 2), $past(SP0_MODE_I, 2)})
      else $error("serial mode readback wrong");
   a_pd_lcd: assert property (LCD_PD_WR_I |-> ##2
      PAD_PD_EN_O[15:2] == ~$past(LCD_PD_INHIBIT_I, 2))
      else $error("lcd pulldown not per inhibit");
   a_pd_sd: assert property (SD_PD_WR_I |-> ##2
      PAD_PD_EN_O[32:21] == ~$past(SD_PD_INHIBIT_I, 2))
      else $error("sd pulldown not per inhibit");
   a_pd_fixed: assert property (PAD_PD_EN_O[1:0] == 2'h0 && PAD_PD_EN_O[20:16] == 5'h00)
      else $error("pulldown on pin without inhibit bit");
   a_pp_rsvd: assert property ($past(ARST_N_I) && PP_MODE_O inside {3'h0, 3'h7} |->
      PIN_SEL_O[20] == {GRP_LCD, 5'h14} && PIN_SEL_O[8] == {GRP_LCD, 5'h08})
      else $error("default parallel mapping missing");
   a_sp1_rsvd: assert property ($past(ARST_N_I) && SP1_MODE_O inside {2'h0, 2'h3} |->
      PIN_SEL_O[27] == {GRP_SD1, 5'h00})
      else $error("default sd1 mapping missing");
   a_spi_ctrl: assert property ($past(ARST_N_I) && PP_MODE_O inside {3'h1, 3'h6} |->
      PIN_SEL_O[17] == {GRP_SPI, 5'h03} && PIN_SEL_O[7] == {GRP_GPIO, 5'h11})
      else $error("spi control mapping wrong");
   a_sd0_i2s: assert property ($past(ARST_N_I) && SP0_MODE_O == 2'h1 |->
      PIN_SEL_O[22] == {GRP_I2S0, 5'h01} && PIN_SEL_O[26] == {GRP_GPIO, 5'h05})
      else $error("sd0 i2s mapping wrong");
endmodule

bind peripheral_pin_mux peripheral_pin_mux_asserts peripheral_pin_mux_asserts_inst (.*);

// *** dv/peripheral_pin_mux_bench.sv ***
`timescale 1ns/1ps
`include "pin_mux_regs.svh"

module peripheral_pin_mux_bench;
   import pin_mux_pkg::*;

   logic CLK_I = 0, ARST_N_I = 0, SEL_WR_I = 0, LCD_PD_WR_I = 0, SD_PD_WR_I = 0;
   logic [2:0] PP_MODE_I = 0;
   logic [1:0] SP1_MODE_I = 0, SP0_MODE_I = 0;
   logic [13:0] LCD_PD_INHIBIT_I = 0;
   logic [11:0] SD_PD_INHIBIT_I = 0;
   logic [`GRP_CNT-1:0][`SIG_CNT-1:0] FUNC_OUT_I = 0, FUNC_OE_I = 0;
   logic [`PIN_CNT-1:0] PAD_IN_I = 0, PAD_PD_EN_O;
   logic [`PIN_CNT-1:0] PAD_OUT_O, PAD_OE_O;
   logic [`GRP_CNT-1:0][`SIG_CNT-1:0] FUNC_IN_O;
   pin_sel_type [`PIN_CNT-1:0] PIN_SEL_O;
   logic [2:0] PP_MODE_O;
   logic [1:0] SP1_MODE_O, SP0_MODE_O;
   logic [31:0] seed = 32'hE027, r;
   logic [15:0] exp_q[$];
   int num_errors = 0, checks_done = 0;
   event look;

   peripheral_pin_mux peripheral_pin_mux_inst (.*);

   always #50 CLK_I = ~CLK_I;

   // ********************************
   // expectations
   // ********************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   function automatic logic [8:0] want(int p, logic [32:0] c);
      int k, g;
      logic [1:0] m;
      bit spi;
      k = p % 4;
      g = k ^ (k >> 1);
      spi = c[32:30] inside {3'h1, 3'h6};
      if (p < 2)
         return spi ? {GRP_SPI, 5'(p + 1)} : {GRP_LCD, 5'(p)};
      if (p < 8)
         return spi ? {GRP_GPIO, 5'(p + 10)} : {GRP_LCD, 5'(p)};
      if (p < 16) begin
         if (c[32:30] == 3'h2)
            return {GRP_GPIO, 5'(p < 11 ? p + 10 : p + 16)};
         if (p < 12 && c[32:30] inside {3'h1, 3'h4, 3'h6})
            return {GRP_I2S2, 5'(g)};
         if (p < 12 && c[32:30] inside {3'h3, 3'h5})
            return {GRP_SPI, 5'((8'h9C >> (2 * k)) & 3)};
         if (p > 11 && c[32:30] inside {3'h1, 3'h4, 3'h5})
            return {GRP_UART, 5'(k)};
         if (p > 11 && c[32:30] inside {3'h3, 3'h6})
            return {GRP_I2S3, 5'(g)};
         return {GRP_LCD, 5'(p)};
      end
      if (p < 21)
         return spi ? {GRP_SPI, 5'(p == 16 ? 0 : p - 14)} : {GRP_LCD, 5'(p)};
      k = (p - 21) % 6;
      m = p < 27 ? c[29:28] : c[27:26];
      g = p < 27 ? 0 : 6;
      if (m == 2'h2 || (m == 2'h1 && k > 3))
         return {GRP_GPIO, 5'(g + k)};
      if (m == 2'h1)
         return {p < 27 ? GRP_I2S0 : GRP_I2S1, 5'(k)};
      return {p < 27 ? GRP_SD0 : GRP_SD1, 5'(k)};
   endfunction

   function automatic logic pd(int p, logic [32:0] c);
      if (p > 1 && p < 16)
         return !c[p + 10];
      if (p > 20)
         return !c[p - 21];
      return 1'b0;
   endfunction

   // ********************************
   // drivers and monitor
   // ********************************
   task automatic note(logic [32:0] c);
      for (int p = 0; p < 33; p++)
         exp_q.push_back({6'(p), pd(p, c), want(p, c)});
      @(negedge CLK_I);
      -> look;
   endtask

   task automatic wr(logic [32:0] c);
      @(negedge CLK_I);
      SEL_WR_I = 1;
      LCD_PD_WR_I = 1;
      SD_PD_WR_I = 1;
      {PP_MODE_I, SP0_MODE_I, SP1_MODE_I, LCD_PD_INHIBIT_I, SD_PD_INHIBIT_I} = c;
   endtask

   task automatic cfg(logic [32:0] c);
      wr(c);
      @(negedge CLK_I);
      SEL_WR_I = 0;
      LCD_PD_WR_I = 0;
      SD_PD_WR_I = 0;
      note(c);
   endtask

   task check(logic [8:0] seen, logic [8:0] wv);
      checks_done++;
      if (seen !== wv) begin
         num_errors++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, wv);
      end
   endtask

   always @(look) begin
      logic [15:0] n;
      while (exp_q.size() > 0) begin
         n = exp_q.pop_front();
         check(PIN_SEL_O[n[15:10]], n[8:0]);
         check(9'(PAD_PD_EN_O[n[15:10]]), 9'(n[9]));
         check(9'(PAD_OUT_O[n[15:10]]), 9'(FUNC_OUT_I[n[8:5]][n[4:0]]));
         check(9'(PAD_OE_O[n[15:10]]), 9'(FUNC_OE_I[n[8:5]][n[4:0]]));
         check(9'(FUNC_IN_O[n[8:5]][n[4:0]]), 9'(PAD_IN_I[n[15:10]]));
      end
   end

   always @(negedge CLK_I) begin
      for (int g = 0; g < `GRP_CNT; g++) begin
         FUNC_OUT_I[g] <= rnd();
         FUNC_OE_I[g] <= rnd();
      end
      PAD_IN_I <= 33'({rnd(), rnd()});
   end

   task print_verdict();
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ********************************
   // sequence
   // ********************************
   initial begin
      repeat (12) @(posedge CLK_I);
      @(negedge CLK_I);
      ARST_N_I = 1;
      note(33'h0);
      for (int i = 0; i < 8; i++) begin
         r = rnd();
         cfg({3'(i), 2'(i), 2'(i + 1), r[25:0]});
      end
      for (int i = 0; i < 24; i++) begin
         r = rnd();
         wr({~r, r[3]});
         cfg({r, r[7]});
      end
      @(negedge CLK_I);
      ARST_N_I = 0;
      @(negedge CLK_I);
      ARST_N_I = 1;
      note(33'h0);
      @(negedge CLK_I);
      print_verdict();
   end

   // about 137 cycles of work; cut off at 5000
   initial begin
      #500_000;
      num_errors++;
      print_verdict();
   end
endmodule
